// file: src/ccsc_pkg.sv
// Purpose: constants for the cpu clock switchover control block
// Assumes: apb register map, 32-bit data, one aligned word each
// Notes:   all offsets are byte addresses
package ccsc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] PROC_CLK_CTRL_OFS  = 8'h00;
  localparam logic [7:0] MAIN_CLK_MODE_OFS  = 8'h04;
  localparam logic [7:0] MAIN_OSC_CTRL_OFS  = 8'h08;
  localparam logic [7:0] INT_OSC_MODE_OFS   = 8'h0c;
  localparam logic [7:0] SETTLE_STATUS_OFS  = 8'h10;
  localparam logic [7:0] SETTLE_SELECT_OFS  = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DIV_LSB          = 0;   // division code, bits 2:0
  localparam int SUBSEL_BIT       = 4;   // subsystem select
  localparam int SUBACT_BIT       = 5;   // subsystem active, read only
  localparam int SUBMODE_STOP_BIT = 7;   // hs osc stop in sub mode
  localparam int MAINSEL_BIT      = 0;   // main source select
  localparam int MAINSTAT_BIT     = 1;   // main source status, ro
  localparam int HS_STOP_BIT      = 7;   // hs osc stop
  localparam int INT_STOP_BIT     = 0;   // internal osc stop

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] DIV_RST      = 3'h0;
  localparam logic [2:0] SETTLE_RST   = 3'h5;
  localparam logic       MAINSEL_RST  = 1'b0;

  // ****************************************************************
  // switchover latencies in pre-switch cpu clocks
  // ****************************************************************
  localparam logic [4:0] DIV_LAT_BASE = 5'h10;  // 16 for code 000
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;   // slowest legal code
  localparam logic [4:0] LEAVE_SUB_LAT = 5'h01; // sub to main
  localparam logic [1:0] MAIN_SW_LAT  = 2'h2;   // internal <-> hs

  // ****************************************************************
  // switchover state
  // ****************************************************************
  typedef enum logic [2:0] {
    SW_IDLE  = 3'b001,   // no change pending
    SW_COUNT = 3'b010,   // counting pre-switch clocks
    SW_SUB   = 3'b100    // waiting for a subsystem clock edge
  } ccsc_sw_t;

endpackage : ccsc_pkg

// file: src/ccsc_tick_div.sv
// Purpose: divides a source clock tick stream by a power of two
// Assumes: source tick is one mclk cycle wide, synchronous to mclk
// Notes:   restart realigns the divider so a new period starts clean
module ccsc_tick_div #(
  parameter int MAX_SHIFT = 4
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstN,
  // source and control
  input  wire logic       srcTick,
  input  wire logic [2:0] shift,
  input  wire logic       restart,
  // divided tick
  output logic            divTick
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (MAX_SHIFT < 0 || MAX_SHIFT > 4) begin : gBadShift
    $error("ccsc_tick_div: MAX_SHIFT must be 0 to 4");
  end

  logic [3:0] cnt_r;
  logic [3:0] limit;
  logic [2:0] shiftClamp;

  // clamp code and form terminal count
  always_comb begin
    shiftClamp = (shift > 3'(MAX_SHIFT)) ? 3'(MAX_SHIFT) : shift;
    limit      = 4'((5'h01 << shiftClamp) - 5'h01);
  end

  // tick on the last source edge of each period
  assign divTick = srcTick && (cnt_r == limit);

  // source edge counter
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cnt_r <= 4'h0;
    end else if (restart) begin
      cnt_r <= 4'h0;
    end else if (srcTick) begin
      cnt_r <= (cnt_r >= limit) ? 4'h0 : cnt_r + 4'h1;
    end
  end

endmodule : ccsc_tick_div

// file: src/cpu_clock_switchover_control.sv
// Purpose: cpu clock source, division and oscillator stop control
// Assumes: source ticks are mclk-synchronous single-cycle pulses
// Notes:   cpu clock is given as a tick stream, switched on edges
//
// Function
// RULE1: cpu clock set by three-bit division code and subsystem select bit 4
// RULE2: old cpu clock keeps running a bounded time after a control write
// RULE3: bit 5 reads whether cpu runs on subsystem or main clock
// RULE4: division change waits 16,8,4,2,1 old clocks; leaving subsystem waits 1
// RULE5: main to subsystem waits at most one subsystem period in old clocks
// RULE6: software never changes division while setting subsystem select
// RULE7: division change with subsystem select cleared in one write works
// RULE8: three fast division codes not written while on internal clock
// RULE9: software waits for oscillator settle before using high-speed clock
// RULE10: settle selection applied only on stop release by irq on hs clock
// RULE11: software sets subsystem select only after subsystem osc settles
// RULE12: both hs stop bits ignored while running on high-speed clock
// RULE13: on internal clock only main stop bit stops the hs oscillator
// RULE14: subsystem mode entered from and left to high-speed clock only
// RULE15: software never clears main source select in subsystem mode
// RULE16: in subsystem mode only the sub-mode stop bit stops hs osc
// RULE17: internal osc stop bit works only when the option allows it
// RULE18: status flags show subsystem, high-speed or internal operation
// RULE19: main mode bit 0 selects source, bit 1 shows source in use
// RULE20: stop bits sit at bit 7 of their control registers; the internal osc stop sits at bit 0 here
// RULE21: changeovers aligned to old and new clock, no runt cycles
//
// Added by the designer: the register offsets and the APB register port.
module cpu_clock_switchover_control #(
  parameter int SETTLE_W = 5
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // clock source ticks
  input  wire logic        hsTick,
  input  wire logic        intTick,
  input  wire logic        subTick,
  // option, settle and stop release
  input  wire logic        intOscStopAllowed,
  input  wire logic [SETTLE_W-1:0] settleStatus,
  input  wire logic        stopRelIrq,
  // cpu clock and oscillator controls
  output logic             cpuTick,
  output logic             hsOscRun,
  output logic             intOscRun,
  output logic [2:0]       settleSelApplied,
  output logic             subActive,
  output logic             mainStatus
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (SETTLE_W < 1 || SETTLE_W > 32) begin : gBadSettle
    $error("cpu_clock_switchover_control: SETTLE_W must be 1 to 32");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                rstMeta_r;
  logic                rstN_r;
  logic                setupPh;
  logic                wrEn;
  logic                addrHit;
  logic [2:0]          divCode_r;     // active division code
  logic                subSel_r;      // software subsystem select
  logic                subAct_r;      // cpu on subsystem clock
  logic                subStop_r;     // hs stop in sub mode
  logic                mainSel_r;     // software main source select
  logic                mainStat_r;    // main source in use
  logic                hsStop_r;      // hs stop on internal clock
  logic                intStop_r;     // internal osc stop request
  logic [2:0]          settleSel_r;
  logic [2:0]          settleApp_r;
  ccsc_pkg::ccsc_sw_t  swState_r;
  logic [2:0]          pendDiv_r;
  logic                pendSub_r;
  logic [4:0]          latCnt_r;
  logic                mainPend_r;
  logic [1:0]          mainCnt_r;
  logic                srcTick;
  logic [2:0]          divShift;
  logic                applyPcc;
  logic                applyMain;
  logic                wrPcc;
  logic                wrMcm;
  logic [2:0]          wrDiv;
  logic                wrSub;
  logic [4:0]          divLat;
  logic [31:0]         rdData;

  // ****************************************************************
  // reset release
  // ****************************************************************

  // two-stage release of the async reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************

  // setup phase captures read data, access phase completes
  assign setupPh = psel && !penable;
  assign wrEn    = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign wrPcc   = wrEn && (paddr == ccsc_pkg::PROC_CLK_CTRL_OFS);
  assign wrMcm   = wrEn && (paddr == ccsc_pkg::MAIN_CLK_MODE_OFS);
  assign wrDiv   = pwdata[ccsc_pkg::DIV_LSB +: 3];

  // decode address hits
  always_comb begin
    case (paddr)
      ccsc_pkg::PROC_CLK_CTRL_OFS,
      ccsc_pkg::MAIN_CLK_MODE_OFS,
      ccsc_pkg::MAIN_OSC_CTRL_OFS,
      ccsc_pkg::INT_OSC_MODE_OFS,
      ccsc_pkg::SETTLE_STATUS_OFS,
      ccsc_pkg::SETTLE_SELECT_OFS: addrHit = 1'b1;
      default:                     addrHit = 1'b0;
    endcase
  end

  // read mux
  always_comb begin
    rdData = 32'h0;
    case (paddr)
      ccsc_pkg::PROC_CLK_CTRL_OFS: begin
        // RULE1: division and select layout
        rdData[ccsc_pkg::DIV_LSB +: 3]         = divCode_r;
        rdData[ccsc_pkg::SUBSEL_BIT]           = subSel_r;
        // RULE3: subsystem active readback
        rdData[ccsc_pkg::SUBACT_BIT]           = subAct_r;
        rdData[ccsc_pkg::SUBMODE_STOP_BIT]     = subStop_r;
      end
      ccsc_pkg::MAIN_CLK_MODE_OFS: begin
        // RULE19: select and status bits
        rdData[ccsc_pkg::MAINSEL_BIT]          = mainSel_r;
        rdData[ccsc_pkg::MAINSTAT_BIT]         = mainStat_r;
      end
      ccsc_pkg::MAIN_OSC_CTRL_OFS: begin
        rdData[ccsc_pkg::HS_STOP_BIT]          = hsStop_r;
      end
      ccsc_pkg::INT_OSC_MODE_OFS: begin
        rdData[ccsc_pkg::INT_STOP_BIT]         = intStop_r;
      end
      ccsc_pkg::SETTLE_STATUS_OFS: begin
        rdData[SETTLE_W-1:0]                   = settleStatus;
      end
      ccsc_pkg::SETTLE_SELECT_OFS: begin
        rdData[2:0]                            = settleSel_r;
      end
      default: begin
        rdData = 32'h0;
      end
    endcase
  end

  // read data and error registered in the setup phase
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata  <= pwrite ? 32'h0 : rdData;
      pslverr <= !addrHit;
    end
  end

  // ****************************************************************
  // software control bits
  // ****************************************************************

  // subsystem select and sub-mode stop
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      subSel_r  <= 1'b0;
      subStop_r <= 1'b0;
    end else if (wrPcc) begin
      // RULE14: entry only from high-speed operation
      subSel_r  <= pwdata[ccsc_pkg::SUBSEL_BIT] && (mainStat_r || subAct_r);
      // RULE20: sub-mode stop at bit 7
      subStop_r <= pwdata[ccsc_pkg::SUBMODE_STOP_BIT];
    end
  end

  // main source select
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      mainSel_r <= ccsc_pkg::MAINSEL_RST;
    end else if (wrMcm) begin
      // RULE14: no move to internal clock from subsystem mode
      // RULE15: a clear request in subsystem mode is dropped
      if (!(subAct_r || subSel_r)) begin
        mainSel_r <= pwdata[ccsc_pkg::MAINSEL_BIT];
      end
    end
  end

  // oscillator stop requests and settle selection
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      hsStop_r    <= 1'b0;
      intStop_r   <= 1'b0;
      settleSel_r <= ccsc_pkg::SETTLE_RST;
    end else if (wrEn) begin
      if (paddr == ccsc_pkg::MAIN_OSC_CTRL_OFS) begin
        // RULE20: main stop at bit 7
        hsStop_r <= pwdata[ccsc_pkg::HS_STOP_BIT];
      end
      if (paddr == ccsc_pkg::INT_OSC_MODE_OFS) begin
        intStop_r <= pwdata[ccsc_pkg::INT_STOP_BIT];
      end
      if (paddr == ccsc_pkg::SETTLE_SELECT_OFS) begin
        settleSel_r <= pwdata[2:0];
      end
    end
  end

  // settle selection taken into use
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      settleApp_r <= ccsc_pkg::SETTLE_RST;
    end else if (stopRelIrq && mainStat_r && !subAct_r) begin
      // RULE10: only on irq release in hs operation
      settleApp_r <= settleSel_r;
    end
  end

  // ****************************************************************
  // cpu clock generation
  // ****************************************************************

  // source mux: subsystem, high-speed or internal
  assign srcTick  = subAct_r ? subTick : (mainStat_r ? hsTick : intTick);
  assign divShift = subAct_r ? 3'h0 : divCode_r;

  // RULE21: divider restarts on every changeover edge
  ccsc_tick_div #(
    .MAX_SHIFT (4)
  ) uDiv (
    .mclk    (mclk),
    .rstN    (rstN_r),
    .srcTick (srcTick),
    .shift   (divShift),
    .restart (applyPcc || applyMain),
    .divTick (cpuTick)
  );

  // ****************************************************************
  // division and subsystem switchover
  // ****************************************************************

  // RULE4: latency set by the old division code
  always_comb begin
    if (subAct_r) begin
      divLat = ccsc_pkg::LEAVE_SUB_LAT;
    end else if (divCode_r > ccsc_pkg::DIV_CODE_MAX) begin
      divLat = 5'(ccsc_pkg::DIV_LAT_BASE >> ccsc_pkg::DIV_CODE_MAX);
    end else begin
      divLat = 5'(ccsc_pkg::DIV_LAT_BASE >> divCode_r);
    end
  end

  // RULE14: only a hs-sourced cpu may move to subsystem
  assign wrSub = pwdata[ccsc_pkg::SUBSEL_BIT] && (mainStat_r || subAct_r);

  // RULE2: new selection lands on an old clock edge
  // RULE5: subsystem entry lands on the next subsystem edge
  assign applyPcc = ((swState_r == ccsc_pkg::SW_COUNT) && cpuTick &&
                     (latCnt_r == 5'h01)) ||
                    ((swState_r == ccsc_pkg::SW_SUB) && subTick);

  // switchover sequencer
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      swState_r <= ccsc_pkg::SW_IDLE;
      pendDiv_r <= ccsc_pkg::DIV_RST;
      pendSub_r <= 1'b0;
      latCnt_r  <= 5'h0;
    end else if (wrPcc) begin
      // RULE7: division and sub clear taken together
      pendDiv_r <= wrDiv;
      pendSub_r <= wrSub;
      latCnt_r  <= divLat;
      if (wrSub && !subAct_r) begin
        swState_r <= ccsc_pkg::SW_SUB;
      end else begin
        swState_r <= ccsc_pkg::SW_COUNT;
      end
    end else begin
      case (swState_r)
        ccsc_pkg::SW_IDLE: begin
          swState_r <= ccsc_pkg::SW_IDLE;
        end
        ccsc_pkg::SW_COUNT: begin
          if (applyPcc) begin
            swState_r <= ccsc_pkg::SW_IDLE;
          end else if (cpuTick) begin
            latCnt_r <= latCnt_r - 5'h01;
          end
        end
        ccsc_pkg::SW_SUB: begin
          if (applyPcc) begin
            swState_r <= ccsc_pkg::SW_IDLE;
          end
        end
        default: begin
          swState_r <= ccsc_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // active division code and subsystem flag
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      divCode_r <= ccsc_pkg::DIV_RST;
      subAct_r  <= 1'b0;
    end else if (applyPcc) begin
      // RULE1: selection takes effect
      divCode_r <= pendDiv_r;
      subAct_r  <= pendSub_r;
    end
  end

  // ****************************************************************
  // internal / high-speed switchover
  // ****************************************************************

  // switch after two old cpu clocks
  assign applyMain = mainPend_r && cpuTick && (mainCnt_r == 2'h1);

  // main source sequencer
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      mainPend_r <= 1'b0;
      mainCnt_r  <= 2'h0;
    end else if (wrMcm && !(subAct_r || subSel_r)) begin
      mainPend_r <= pwdata[ccsc_pkg::MAINSEL_BIT] != mainStat_r;
      mainCnt_r  <= ccsc_pkg::MAIN_SW_LAT;
    end else if (applyMain) begin
      mainPend_r <= 1'b0;
    end else if (mainPend_r && cpuTick) begin
      mainCnt_r <= mainCnt_r - 2'h1;
    end
  end

  // RULE19: status follows the source in use
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      mainStat_r <= ccsc_pkg::MAINSEL_RST;
    end else if (applyMain) begin
      mainStat_r <= mainSel_r;
    end
  end

  // ****************************************************************
  // oscillator gating and status outputs
  // ****************************************************************

  // high-speed oscillator run control
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      hsOscRun <= 1'b1;
    end else if (subAct_r) begin
      // RULE16: only the sub-mode stop applies
      hsOscRun <= !subStop_r;
    end else if (mainStat_r) begin
      // RULE12: both stop bits ignored
      hsOscRun <= 1'b1;
    end else begin
      // RULE13: only the main stop applies
      hsOscRun <= !hsStop_r;
    end
  end

  // internal oscillator run control
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      intOscRun <= 1'b1;
    end else begin
      // RULE17: stop honoured only when the option allows
      intOscRun <= !(intOscStopAllowed && intStop_r &&
                     (mainStat_r || subAct_r));
    end
  end

  // RULE18: status flags per operating mode
  assign subActive        = subAct_r;
  assign mainStatus       = mainStat_r;
  assign settleSelApplied = settleApp_r;

endmodule : cpu_clock_switchover_control

// file: dv/ccsc_chk.sv
// Purpose: port checker for cpu clock switchover control
// Assumes: apb map as in ccsc_pkg, pready tied high
// Notes:   bound to every instance of the top module
module ccsc_chk (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // apb
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic [7:0] paddr,
  input  wire logic       pready,
  input  wire logic       pslverr,
  // control and status
  input  wire logic       stopRelIrq,
  input  wire logic       intOscStopAllowed,
  input  wire logic       hsOscRun,
  input  wire logic       intOscRun,
  input  wire logic [2:0] settleSelApplied,
  input  wire logic       subActive,
  input  wire logic       mainStatus
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // setup on an unmapped word, then its access
  sequence badSetup_s;
    psel && !penable && (paddr > 8'h14 || paddr[1:0] != 2'h0);
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  bad_addr_err_a: assert property (
    badSetup_s ##1 access_s |-> pslverr && pready)
    else $error("unmapped access without error");
  sub_on_main_a: assert property (subActive |-> mainStatus)
    else $error("subsystem flag without main status");
  sub_entry_hs_a: assert property (
    $rose(subActive) |-> $past(mainStatus))
    else $error("subsystem entered from internal clock");
  main_drop_a: assert property (
    $fell(mainStatus) |-> !$past(subActive))
    else $error("internal clock entered from subsystem");
  hs_keep_run_a: assert property (
    (mainStatus && !subActive)[*3] |-> hsOscRun)
    else $error("hs oscillator stopped while in use");
  int_keep_run_a: assert property ((!mainStatus)[*3] |-> intOscRun)
    else $error("internal oscillator stopped while in use");
  int_no_stop_a: assert property (
    (!intOscStopAllowed)[*3] |-> intOscRun)
    else $error("internal oscillator stopped against option");
  settle_hold_a: assert property (
    $changed(settleSelApplied) |->
      $past(stopRelIrq && mainStatus && !subActive))
    else $error("settle select applied without release");
endmodule : ccsc_chk

bind cpu_clock_switchover_control ccsc_chk i_ccsc_chk (
  .mclk, .rst_b, .psel, .penable, .paddr, .pready, .pslverr,
  .stopRelIrq, .intOscStopAllowed, .hsOscRun, .intOscRun,
  .settleSelApplied, .subActive, .mainStatus);

// file: dv/tb.sv
// Purpose: self-checking bench for cpu clock switchover control
// Assumes: hs tick every cycle, internal every 2nd, subsystem every 24th
// Notes:   shadow bits model register state and oscillator controls
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] aPcc = ccsc_pkg::PROC_CLK_CTRL_OFS;
  localparam logic [7:0] aMcm = ccsc_pkg::MAIN_CLK_MODE_OFS;
  localparam logic [7:0] aMoc = ccsc_pkg::MAIN_OSC_CTRL_OFS;
  localparam logic [7:0] aRcm = ccsc_pkg::INT_OSC_MODE_OFS;
  localparam logic [7:0] aSt  = ccsc_pkg::SETTLE_STATUS_OFS;
  localparam logic [7:0] aSel = ccsc_pkg::SETTLE_SELECT_OFS;
  logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hsTick = 1'b0, intTick = 1'b0, subTick = 1'b0;
  logic intOscStopAllowed = 1'b0, stopRelIrq = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [4:0] settleStatus = 5'h0;
  logic [2:0] settleSelApplied;
  logic pready, pslverr, cpuTick, hsOscRun, intOscRun, subActive;
  logic mainStatus;
  int cyc = 0, nErrors = 0, nTests = 0, c = 0;
  bit highspeed_osc_stop_submode, highspeed_osc_stop, internal_osc_stop, onHs, onSub;

  // ****************************************************************
  // clock, source ticks, timeout
  // ****************************************************************
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    hsTick <= 1'b1;
    intTick <= (cyc % 2 == 0);
    subTick <= (cyc % 24 == 0);
    if (cyc == 30000) begin
      nErrors++;
      complete_run();
    end
  end

  cpu_clock_switchover_control #(.SETTLE_W(5)) i_cpu_clock_switchover_control (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .hsTick(hsTick),
    .intTick(intTick), .subTick(subTick),
    .intOscStopAllowed(intOscStopAllowed), .settleStatus(settleStatus),
    .stopRelIrq(stopRelIrq), .cpuTick(cpuTick), .hsOscRun(hsOscRun),
    .intOscRun(intOscRun), .settleSelApplied(settleSelApplied),
    .subActive(subActive), .mainStatus(mainStatus));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic complete_run();
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, g);
    nTests++;
    if (g !== e) begin
      nErrors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer, held until pready at a rising edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] d,
                      output logic s);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    d = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic s;
    xfer(a, 1'b1, d, x, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic er);
    logic [31:0] d;
    logic s;
    xfer(a, 1'b0, 32'h0, d, s);
    chk("prdata", e, d);
    chk("pslverr", {31'h0, er}, {31'h0, s});
  endtask : rd

  // oscillator outputs against the shadow model
  task automatic oscChk();
    bit eh;
    eh = onSub ? !highspeed_osc_stop_submode : (onHs ? 1'b1 : !highspeed_osc_stop);
    repeat (3) @(negedge mclk);
    chk("hsOscRun", {31'h0, eh}, {31'h0, hsOscRun});
    chk("intOscRun", {31'h0, !(intOscStopAllowed && internal_osc_stop &&
        (onHs || onSub))}, {31'h0, intOscRun});
  endtask : oscChk

  task automatic waitSt(input logic ms, input logic sa);
    int k;
    for (k = 0; k < 300 && !(mainStatus === ms && subActive === sa);
         k++) @(negedge mclk);
    chk("mainStatus", {31'h0, ms}, {31'h0, mainStatus});
    chk("subActive", {31'h0, sa}, {31'h0, subActive});
  endtask : waitSt

  task automatic per(output int p);
    p = 0;
    do @(negedge mclk); while (cpuTick !== 1'b1);
    do begin
      @(negedge mclk);
      p++;
    end while (cpuTick !== 1'b1);
  endtask : per

  task automatic pulse(input logic [2:0] e);
    @(posedge mclk);
    stopRelIrq <= 1'b1;
    @(posedge mclk);
    stopRelIrq <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("settleSel", {29'h0, e}, {29'h0, settleSelApplied});
  endtask : pulse

  // division change on the hs clock, old period kept first
  task automatic divTest(input int n);
    int p, l, k;
    l = 16 >> c;
    wr(aPcc, 32'(n));
    per(p);
    if (l >= 4) chk("oldPeriod", 32'(1 << c), 32'(p));
    for (k = 0; k < l; k++) per(p);
    per(p);
    chk("newPeriod", 32'(1 << n), 32'(p));
    c = n;
  endtask : divTest

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int n, p;
    void'($urandom(72));
    settleStatus <= 5'($urandom);
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(aPcc, 32'h0, 1'b0);
    rd(aMcm, 32'h0, 1'b0);
    rd(aSel, 32'h5, 1'b0);
    rd(aSt, {27'h0, settleStatus}, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    intOscStopAllowed <= 1'b1;
    {highspeed_osc_stop, internal_osc_stop} = 2'b11;
    wr(aMoc, 32'h80);
    wr(aRcm, 32'h1);
    oscChk();
    {highspeed_osc_stop, highspeed_osc_stop_submode} = 2'b01;
    wr(aMoc, 32'h0);
    // no subsystem select on internal clock
    wr(aPcc, 32'h90);
    oscChk();
    rd(aPcc, 32'h80, 1'b0);
    wr(aSel, 32'h6);
    pulse(3'h5);
    onHs = 1;
    wr(aMcm, 32'h1);
    waitSt(1'b1, 1'b0);
    rd(aMcm, 32'h3, 1'b0);
    highspeed_osc_stop = 1;
    wr(aMoc, 32'h80);
    oscChk();
    @(posedge mclk);
    intOscStopAllowed <= 1'b0;
    oscChk();
    pulse(3'h6);
    {highspeed_osc_stop_submode, highspeed_osc_stop} = 2'b00;
    wr(aMoc, 32'h0);
    wr(aPcc, 32'h0);
    repeat (6) divTest($urandom_range(4));
    onSub = 1;
    wr(aPcc, 32'h10 | 32'(c));
    waitSt(1'b1, 1'b1);
    rd(aPcc, 32'h30 | 32'(c), 1'b0);
    highspeed_osc_stop = 1;
    wr(aMoc, 32'h80);
    oscChk();
    highspeed_osc_stop_submode = 1;
    wr(aPcc, 32'h90 | 32'(c));
    oscChk();
    wr(aMcm, 32'h0);
    rd(aMcm, 32'h3, 1'b0);
    {onSub, highspeed_osc_stop_submode} = 2'b00;
    n = $urandom_range(4);
    wr(aPcc, 32'(n));
    waitSt(1'b1, 1'b0);
    per(p);
    per(p);
    chk("leavePeriod", 32'(1 << n), 32'(p));
    onHs = 0;
    wr(aMcm, 32'h0);
    waitSt(1'b0, 1'b0);
    rd(aMcm, 32'h0, 1'b0);
    oscChk();
    complete_run();
  end
endmodule : tb
